/* File: rcl_board.sv */
`timescale 1ns/1ps
`default_nettype none
module rcl_board
  import rcl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_output_n,
  input wire logic [3:0] grp_oe,
  input wire logic [31:0] word,
  output logic [31:0] data_in
);
  logic [31:0] noise_q = 32'h3c3c5a5a;
  logic [31:0] oe_m;
  // A floating bus shows a pattern that changes every cycle.
  always @(posedge sys_clk)
  begin
    noise_q <= ~noise_q;
  end
  assign oe_m = {{10{grp_oe[3]}}, {8{grp_oe[2]}}, {8{grp_oe[1]}}, {6{grp_oe[0]}}};
  // Buffers drive whole chosen groups only while reset output is low.
  assign data_in = reset_output_n ? noise_q : (word & oe_m) | (noise_q & ~oe_m);
endmodule
`default_nettype wire

/* File: rcl_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module rcl_decode
  import rcl_pkg::*;
(
  input wire logic [31:0] cfg_word,
  output logic min_bus_mode,
  output logic [31:0] vector_base,
  output logic burst_last_timing,
  output logic boot_chip_select_async,
  output logic boot_chip_select_32bit,
  output logic [2:0] boot_wait_states,
  output logic [1:0] instruction_memory_base,
  output logic [1:0] load_memory_base,
  output logic [4:0] bus_pin_enable,
  output logic lbus_memory_enable,
  output logic port_replacement_mode,
  output logic addr_hi_enable
);
  // Field split of the latched word; reserved bits are not looked at.
  assign min_bus_mode = cfg_word[RCL_BIT_MIN_BUS];
  assign vector_base = cfg_word[RCL_BIT_VEC_HIGH] ? 32'hffff0000 : 32'h00000000;
  assign burst_last_timing = cfg_word[RCL_BIT_BURST_LAST];
  assign boot_chip_select_async = cfg_word[RCL_BIT_BOOT_ASYNC];
  assign boot_chip_select_32bit = cfg_word[RCL_BIT_BOOT_32];
  // Multi-bit fields except bus_pin_enable take their lowest-numbered bit as the most significant one.
  assign boot_wait_states = {cfg_word[RCL_BIT_WAIT_LO], cfg_word[RCL_BIT_WAIT_LO + 1],
                             cfg_word[RCL_BIT_WAIT_LO + 2]};
  assign instruction_memory_base = {cfg_word[RCL_BIT_IMEM_LO],
                                    cfg_word[RCL_BIT_IMEM_LO + 1]};
  assign load_memory_base = {cfg_word[RCL_BIT_LMEM_LO],
                             cfg_word[RCL_BIT_LMEM_LO + 1]};
  assign bus_pin_enable = cfg_word[RCL_BIT_ATTR +: 5];
  assign addr_hi_enable = cfg_word[RCL_BIT_ADDR_HI];
  assign lbus_memory_enable = cfg_word[RCL_BIT_LMEM_EN];
  assign port_replacement_mode = cfg_word[RCL_BIT_PORT_REPL];
endmodule
`default_nettype wire

/* File: rcl_pkg.sv */
package rcl_pkg;
  localparam int RCL_CLK_MHZ = 100;
  localparam int RCL_RELEASE_CLKS = 17;
  localparam int RCL_SAMPLE_CLKS = 5;
  localparam int RCL_CNT_W = 5;
  localparam logic [RCL_CNT_W-1:0] RCL_RELEASE_CNT = 5'h11;
  localparam logic [RCL_CNT_W-1:0] RCL_SAMPLE_CNT = 5'h05;
  localparam int RCL_BIT_MIN_BUS = 0;
  localparam int RCL_BIT_VEC_HIGH = 1;
  localparam int RCL_BIT_BURST_LAST = 2;
  localparam int RCL_BIT_BOOT_ASYNC = 3;
  localparam int RCL_BIT_BOOT_32 = 4;
  localparam int RCL_BIT_CHAIN0 = 5;
  localparam int RCL_BIT_WAIT_LO = 6;
  localparam int RCL_BIT_IMEM_LO = 9;
  localparam int RCL_BIT_LMEM_LO = 11;
  localparam int RCL_BIT_CHAIN1 = 13;
  localparam int RCL_BIT_ATTR = 14;
  localparam int RCL_BIT_WRBURST = 15;
  localparam int RCL_BIT_DBGTRK = 16;
  localparam int RCL_BIT_HSHAKE = 17;
  localparam int RCL_BIT_ARB = 18;
  localparam int RCL_BIT_PLL_WAIT = 19;
  localparam int RCL_BIT_CHAIN2 = 21;
  localparam int RCL_BIT_LMEM_EN = 24;
  localparam int RCL_BIT_PORT_REPL = 25;
  localparam int RCL_BIT_ADDR_HI = 26;
  localparam logic [31:0] RCL_DEFAULT_3V = 32'hc507dc99;
  localparam logic [31:0] RCL_DEFAULT_TTL = 32'hc50fdbcb;
  localparam logic [31:0] RCL_RESERVED_MASK = 32'h38d00000;
  typedef enum logic [1:0] {
    RCL_ST_HOLD = 2'b00,
    RCL_ST_COUNT = 2'b01,
    RCL_ST_RUN = 2'b11
  } rcl_state_t;
endpackage

/* File: rcl_reset_config.sv */
`timescale 1ns/1ps
`default_nettype none
module rcl_reset_config
  import rcl_pkg::*;
#(
  parameter bit TTL_VARIANT = 1'b0
)(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ext_reset_n,
  input wire logic int_reset_req,
  input wire logic supply_sense_strap,
  input wire logic clock_mode_strap,
  input wire logic debug_input_strap,
  input wire logic debug_clock_strap,
  input wire logic [31:0] data_in,
  input wire logic bus_grant_n,
  input wire logic pll_locked,
  input wire logic timebase_expired,
  output logic reset_output_n,
  output logic debug_enable,
  output logic bus_config_mode,
  output logic [31:0] config_word,
  output logic min_bus_mode,
  output logic [31:0] vector_base,
  output logic burst_last_timing,
  output logic boot_chip_select_async,
  output logic boot_chip_select_32bit,
  output logic [2:0] boot_wait_states,
  output logic [1:0] instruction_memory_base,
  output logic [1:0] load_memory_base,
  output logic [4:0] bus_pin_enable,
  output logic lbus_memory_enable,
  output logic port_replacement_mode,
  output logic addr_hi_enable
);
  localparam logic [31:0] DEFAULT_WORD = TTL_VARIANT ? RCL_DEFAULT_TTL : RCL_DEFAULT_3V;

  logic [39:0] sync_bus;
  logic ext_n_s;
  logic int_req_s;
  logic sense_s;
  logic clkmode_s;
  logic dsi_s;
  logic dck_s;
  logic grant_n_s;
  logic lock_s;
  logic [31:0] data_s;
  rcl_state_t state_q;
  logic [RCL_CNT_W-1:0] rel_cnt_q;
  logic [RCL_CNT_W-1:0] smp_cnt_q;
  logic ext_n_d1_q;
  logic [31:0] cfg_bus_q;
  logic [31:0] cfg_hold_q;
  logic dsi_q;
  logic dck_q;
  logic rel_ok;
  logic latch_now;
  logic ext_neg;

  rcl_sync #(.WIDTH(40)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({ext_reset_n, int_reset_req, supply_sense_strap, clock_mode_strap,
               debug_input_strap, debug_clock_strap, bus_grant_n, pll_locked, data_in}),
    .sync_out(sync_bus)
  );
  assign {ext_n_s, int_req_s, sense_s, clkmode_s, dsi_s, dck_s, grant_n_s, lock_s} =
    sync_bus[39:32];
  assign data_s = sync_bus[31:0];

  // Builds the word from the pins, chaining groups on bits 5, 13 and 21.
  function automatic logic [31:0] rcl_merge(input logic [31:0] pins, input logic [31:0] dflt);
    logic [31:0] w;
    w = dflt;
    w[5:0] = pins[5:0];
    if (w[RCL_BIT_CHAIN0])
    begin
      w[13:6] = pins[13:6];
    end
    if (w[RCL_BIT_CHAIN0] && w[RCL_BIT_CHAIN1])
    begin
      w[21:14] = pins[21:14];
    end
    if (w[RCL_BIT_CHAIN0] && w[RCL_BIT_CHAIN1] && w[RCL_BIT_CHAIN2])
    begin
      w[31:22] = pins[31:22];
    end
    return w;
  endfunction

  assign ext_neg = ext_n_s && !ext_n_d1_q;

  // Release condition per clock mode, once the 17-clock hold has run out; with PLL wait off in normal mode a time-out releases at any count.
  always_comb
  begin
    rel_ok = 1'b0;
    if (rel_cnt_q >= RCL_RELEASE_CNT)
    begin
      if (sense_s && !clkmode_s)
      begin
        rel_ok = lock_s;
      end
      else if (sense_s && clkmode_s && !cfg_bus_q[RCL_BIT_PLL_WAIT])
      begin
        rel_ok = lock_s;
      end
      else
      begin
        rel_ok = 1'b1;
      end
    end
    if (sense_s && clkmode_s && !cfg_bus_q[RCL_BIT_PLL_WAIT] && timebase_expired)
    begin
      rel_ok = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_n_d1_q <= 1'b0;
    end
    else
    begin
      ext_n_d1_q <= ext_n_s;
    end
  end

  // Reset sequencer; an external reset at any point restarts the flow.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= RCL_ST_HOLD;
      rel_cnt_q <= '0;
    end
    else if (!ext_n_s)
    begin
      state_q <= RCL_ST_HOLD;
      rel_cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        RCL_ST_HOLD:
        begin
          state_q <= RCL_ST_COUNT;
          rel_cnt_q <= 5'h01;
        end
        RCL_ST_COUNT:
        begin
          if (rel_cnt_q < RCL_RELEASE_CNT)
          begin
            rel_cnt_q <= rel_cnt_q + 5'h01;
          end
          if (rel_ok)
          begin
            state_q <= RCL_ST_RUN;
          end
        end
        RCL_ST_RUN:
        begin
          if (int_req_s)
          begin
            state_q <= RCL_ST_COUNT;
            rel_cnt_q <= '0;
          end
        end
        default:
        begin
          state_q <= RCL_ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reset_output_n <= 1'b0;
    end
    else
    begin
      reset_output_n <= (state_q == RCL_ST_RUN) && ext_n_s && !(int_req_s);
    end
  end

  // Counts to the sampling point: after pin negation or reset output assertion.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      smp_cnt_q <= '0;
    end
    else if (!ext_n_s || (reset_output_n && int_req_s))
    begin
      smp_cnt_q <= '0;
    end
    else if (!reset_output_n && smp_cnt_q <= RCL_SAMPLE_CNT)
    begin
      smp_cnt_q <= smp_cnt_q + 5'h01;
    end
  end

  assign latch_now = !reset_output_n && (smp_cnt_q == RCL_SAMPLE_CNT) && !ext_neg;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dsi_q <= 1'b0;
      dck_q <= 1'b0;
    end
    else
    begin
      if (latch_now)
      begin
        dsi_q <= dsi_s;
      end
      if (!reset_output_n)
      begin
        dck_q <= dck_s;
      end
    end
  end

  assign debug_enable = dck_q;
  assign bus_config_mode = dsi_q;

  // Internal configuration bus: default until a pin word is latched.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_bus_q <= DEFAULT_WORD;
    end
    else if (latch_now)
    begin
      if (dsi_s && !grant_n_s)
      begin
        cfg_bus_q <= rcl_merge(data_s, DEFAULT_WORD);
      end
      else
      begin
        cfg_bus_q <= DEFAULT_WORD;
      end
    end
  end

  // Functions capture on the negation of the internal reset and then hold.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_hold_q <= DEFAULT_WORD & ~RCL_RESERVED_MASK;
    end
    else if (!reset_output_n && state_q == RCL_ST_RUN)
    begin
      cfg_hold_q <= cfg_bus_q & ~RCL_RESERVED_MASK;
    end
  end

  assign config_word = cfg_hold_q;

  rcl_decode u_decode (
    .cfg_word(cfg_hold_q),
    .min_bus_mode(min_bus_mode),
    .vector_base(vector_base),
    .burst_last_timing(burst_last_timing),
    .boot_chip_select_async(boot_chip_select_async),
    .boot_chip_select_32bit(boot_chip_select_32bit),
    .boot_wait_states(boot_wait_states),
    .instruction_memory_base(instruction_memory_base),
    .load_memory_base(load_memory_base),
    .bus_pin_enable(bus_pin_enable),
    .lbus_memory_enable(lbus_memory_enable),
    .port_replacement_mode(port_replacement_mode),
    .addr_hi_enable(addr_hi_enable)
  );
endmodule
`default_nettype wire

/* File: rcl_reset_config_props.sv */
`timescale 1ns/1ps
`default_nettype none
module rcl_reset_config_props
  import rcl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ext_reset_n,
  input wire logic supply_sense_strap,
  input wire logic clock_mode_strap,
  input wire logic pll_locked,
  input wire logic timebase_expired,
  input wire logic reset_output_n,
  input wire logic debug_enable,
  input wire logic bus_config_mode,
  input wire logic [31:0] config_word,
  input wire logic min_bus_mode,
  input wire logic [31:0] vector_base
);
  logic [4:0] ext_hi_q;
  // Counts the cycles that the reset pin has stayed negated.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ext_hi_q <= 5'h0;
    else if (!ext_reset_n)
      ext_hi_q <= 5'h0;
    else if (ext_hi_q != 5'h1f)
      ext_hi_q <= ext_hi_q + 5'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  release_after_17_a: assert property (
    $rose(reset_output_n) && !$past(timebase_expired) |-> ext_hi_q >= RCL_RELEASE_CNT)
    else $error("reset output released too early");
  one_to_one_lock_a: assert property (
    $rose(reset_output_n) && supply_sense_strap && !clock_mode_strap |-> $past(pll_locked, 2))
    else $error("one to one release without lock");
  normal_wait_a: assert property (
    $rose(reset_output_n) && supply_sense_strap && clock_mode_strap
    && !config_word[RCL_BIT_PLL_WAIT] |-> $past(pll_locked, 2) || $past(timebase_expired))
    else $error("normal release without lock or time-out");
  ext_restart_a: assert property (
    !ext_reset_n ##1 !ext_reset_n |-> ##[0:4] !reset_output_n)
    else $error("reset pin did not restart reset");
  config_hold_a: assert property (
    reset_output_n && $past(reset_output_n) |-> $stable(config_word)
    && $stable(debug_enable) && $stable(bus_config_mode))
    else $error("configuration changed after release");
  word_change_a: assert property (
    !$stable(config_word) |-> !$past(reset_output_n))
    else $error("configuration word changed outside reset");
  reserved_zero_a: assert property (
    (config_word & RCL_RESERVED_MASK) == 32'h0)
    else $error("reserved configuration bit set");
  vector_base_a: assert property (
    vector_base == (config_word[1] ? 32'hffff0000 : 32'h0))
    else $error("vector base mismatch");
  min_bus_a: assert property (
    min_bus_mode == config_word[0])
    else $error("bus mode mismatch");
endmodule
bind rcl_reset_config rcl_reset_config_props rcl_reset_config_props_inst (
  .sys_clk, .rst_b, .ext_reset_n, .supply_sense_strap, .clock_mode_strap,
  .pll_locked, .timebase_expired, .reset_output_n, .debug_enable,
  .bus_config_mode, .config_word, .min_bus_mode, .vector_base
);
`default_nettype wire

/* File: rcl_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rcl_sync
  import rcl_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: tb_reset_config_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_reset_config_latch;
  import rcl_pkg::*;
  typedef struct packed {logic [31:0] w; logic d; logic b;} rcl_exp_t;
  rcl_exp_t exp_q[$];
  rcl_exp_t e;
  logic sys_clk = 1'b0, rst_b = 1'b0, ext_reset_n = 1'b1, int_reset_req = 1'b0;
  logic supply_sense_strap = 1'b0, clock_mode_strap = 1'b1, debug_input_strap = 1'b0;
  logic debug_clock_strap = 1'b0, bus_grant_n = 1'b0, pll_locked = 1'b0;
  logic timebase_expired = 1'b0, ro_q = 1'b0;
  logic reset_output_n, debug_enable, bus_config_mode;
  logic burst_last_timing, boot_chip_select_async, boot_chip_select_32bit, addr_hi_enable;
  logic lbus_memory_enable, port_replacement_mode;
  logic [2:0] boot_wait_states;
  logic [1:0] instruction_memory_base, load_memory_base;
  logic [4:0] bus_pin_enable;
  logic [17:0] fld_x, fld_s;
  logic [31:0] data_in, config_word, word = 32'h0;
  logic [3:0] grp_oe = 4'h1;
  int error_cnt = 0, n_checks = 0, seed = 32'h42ed;

  rcl_reset_config rcl_reset_config_inst (
    .sys_clk, .rst_b, .ext_reset_n, .int_reset_req, .supply_sense_strap,
    .clock_mode_strap, .debug_input_strap, .debug_clock_strap, .data_in,
    .bus_grant_n, .pll_locked, .timebase_expired, .reset_output_n, .debug_enable,
    .bus_config_mode, .config_word, .min_bus_mode(), .vector_base(),
    .burst_last_timing, .boot_chip_select_async, .boot_chip_select_32bit,
    .boot_wait_states, .instruction_memory_base, .load_memory_base,
    .bus_pin_enable, .lbus_memory_enable, .port_replacement_mode,
    .addr_hi_enable
  );
  rcl_board rcl_board_inst (.sys_clk, .reset_output_n, .grp_oe, .word, .data_in);

  initial forever #5 sys_clk = ~sys_clk;

  task automatic wrap_up();
    chk("expect_queue", 32'h0, 32'(exp_q.size()));
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    n_checks++;
    if (s !== x)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic wait_lvl(input logic v, input int lim);
    int i = 0;
    while (reset_output_n !== v && i < lim)
    begin
      tick(1);
      i++;
    end
    if (reset_output_n !== v)
    begin
      chk("reset_output_n", 32'(v), 32'(reset_output_n));
      wrap_up();
    end
  endtask

  function automatic logic [31:0] chain_exp(input logic [31:0] p);
    logic [31:0] m;
    m = {{10{p[5] & p[13] & p[21]}}, {8{p[5] & p[13]}}, {8{p[5]}}, 6'h3f};
    return (p & m) | (RCL_DEFAULT_3V & ~m);
  endfunction

  task automatic ext_flow(input logic [31:0] w, input logic d, input logic b,
                          input logic [1:0] rel);
    exp_q.push_back({w & ~RCL_RESERVED_MASK, d, b});
    ext_reset_n = 1'b0;
    debug_clock_strap = ~d;
    tick(4);
    debug_clock_strap = d;
    ext_reset_n = 1'b1;
    if (rel != 2'b00)
    begin
      tick(45);
      chk("reset_output_n", 32'h0, 32'(reset_output_n));
      {pll_locked, timebase_expired} = rel;
    end
    wait_lvl(1'b1, 200);
    tick(2);
    debug_clock_strap = ~d;
    {pll_locked, timebase_expired} = 2'b00;
  endtask

  // Compares each released configuration with the oldest note.
  always @(negedge sys_clk)
  begin
    if (rst_b === 1'b1 && reset_output_n === 1'b1 && ro_q === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk("expect_queue", 32'h1, 32'h0);
      else
      begin
        e = exp_q.pop_front();
        chk("config_word", e.w, config_word);
        chk("debug_enable", 32'(e.d), 32'(debug_enable));
        chk("bus_config_mode", 32'(e.b), 32'(bus_config_mode));
        fld_x = {e.w[4:2], e.w[6], e.w[7], e.w[8], e.w[9], e.w[10], e.w[11], e.w[12],
                 e.w[18:14], e.w[26], e.w[24], e.w[25]};
        fld_s = {boot_chip_select_32bit, boot_chip_select_async, burst_last_timing,
                 boot_wait_states, instruction_memory_base, load_memory_base, bus_pin_enable,
                 addr_hi_enable, lbus_memory_enable, port_replacement_mode};
        chk("decoded_fields", 32'(fld_x), 32'(fld_s));
      end
    end
    ro_q = reset_output_n;
  end

  initial
  begin
    exp_q.push_back({RCL_DEFAULT_3V & ~RCL_RESERVED_MASK, 1'b0, 1'b0});
    tick(16);
    rst_b = 1'b1;
    wait_lvl(1'b1, 200);
    tick(2);
    $display("test power_up done");
    debug_input_strap = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      word = $random(seed);
      word[5] = k > 0;
      word[13] = k > 1;
      word[21] = k > 2;
      grp_oe = {word[21] & word[13] & word[5], word[13] & word[5], word[5], 1'b1};
      bus_grant_n = k == 4;
      ext_flow(k == 4 ? RCL_DEFAULT_3V : chain_exp(word), word[0], 1'b1, 2'b00);
    end
    bus_grant_n = 1'b0;
    $display("test chain done");
    supply_sense_strap = 1'b1;
    debug_input_strap = 1'b0;
    ext_flow(RCL_DEFAULT_3V, 1'b1, 1'b0, 2'b10);
    debug_input_strap = 1'b1;
    word[19] = 1'b1;
    ext_flow(chain_exp(word), 1'b1, 1'b1, 2'b00);
    word[19] = 1'b0;
    ext_flow(chain_exp(word), 1'b0, 1'b1, 2'b01);
    clock_mode_strap = 1'b0;
    debug_input_strap = 1'b0;
    timebase_expired = 1'b1;
    ext_flow(RCL_DEFAULT_3V, 1'b0, 1'b0, 2'b11);
    $display("test clock_modes done");
    supply_sense_strap = 1'b0;
    clock_mode_strap = 1'b1;
    debug_input_strap = 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      word = $random(seed) | 32'h202020;
      grp_oe = 4'hf;
      debug_clock_strap = 1'b1;
      exp_q.push_back({word & ~RCL_RESERVED_MASK, 1'b1, 1'b1});
      int_reset_req = 1'b1;
      wait_lvl(1'b0, 100);
      int_reset_req = 1'b0;
      tick(8);
      ext_reset_n = r == 0;
      tick(3);
      ext_reset_n = 1'b1;
      wait_lvl(1'b1, 200);
      tick(2);
    end
    $display("test internal done");
    wrap_up();
  end
endmodule
`default_nettype wire
